// File: hdl/supply_fault.sv
// Supply-voltage fault detection, recovery and register slave
`timescale 1ns/1ps
module supply_fault #(
	parameter int RETRY_CYCLES = supply_fault_pkg::RETRY_CYC
) (
	input  wire logic                                sys_clk,     // 40 MHz clock
	input  wire logic                                rstn,        // Sync reset, low
	input  wire logic [supply_fault_pkg::ADDR_W-1:0] addr,        // Register index
	input  wire logic [supply_fault_pkg::DATA_W-1:0] wdata,       // Write data
	input  wire logic                                wr,          // Write strobe
	input  wire logic                                rd,          // Read strobe
	output logic      [supply_fault_pkg::DATA_W-1:0] rdata,       // Read data, next cycle
	input  wire logic [supply_fault_pkg::VM_W-1:0]   vm_level,    // Supply, 0.1 V units
	output logic                                     drive_en,    // Motor drive allowed
	output logic                                     fault_out,   // Any supply fault
	output logic                                     irq          // Level interrupt
);
	import supply_fault_pkg::*;

	initial
	begin
		if (RETRY_CYCLES < 1 || RETRY_CYCLES > 32'h00ff_ffff)
			$error("supply_fault: RETRY_CYCLES out of range");
	end

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] idx);
		hit = (a == idx);
	endfunction

	logic [DATA_W-1:0]    fault2_r, fault2_nxt;
	logic [NUM_EVT-1:0]   istat_r, imask_r;
	logic [DATA_W-1:0]    rdata_loc_r;
	logic                 rd_bank_r;
	logic                 uv_fault_r, ov_fault_r;
	logic [4:0]           tries_r;
	logic [23:0]          wait_cnt_r;
	fault_state_type      st_r, st_nxt;

	// Register decode
	wire [NUM_HW_CFG-1:0] bank_hit;
	wire [NUM_HW_CFG-1:0] bank_wr;
	wire [$clog2(NUM_HW_CFG)-1:0] bank_idx;
	for (genvar i = 0; i < NUM_HW_CFG; i++)
	begin : g_dec
		assign bank_hit[i] = hit(addr, HW_CFG_BASE + ADDR_W'(i) * HW_CFG_STEP);
		assign bank_wr[i]  = wr && bank_hit[i];
	end
	wire any_bank = |bank_hit;
	assign bank_idx = 3'((addr - HW_CFG_BASE) >> 1);
	wire wr_fault2 = wr && hit(addr, IDX_FAULT2);
	wire wr_istat  = wr && hit(addr, IDX_IRQ_STAT);
	wire wr_imask  = wr && hit(addr, IDX_IRQ_MASK);
	wire wr_clear  = wr && hit(addr, IDX_CLEAR) && wdata[CLR_BIT];

	wire [DATA_W-1:0] bank_rdata;
	cfg_regs #(.N(NUM_HW_CFG)) u_bank (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.wr_sel  (bank_wr),
		.wdata   (wdata),
		.rd_idx  (any_bank ? bank_idx : 3'h0),
		.rdata   (bank_rdata)
	);

	// Field extraction
	wire [FLD_W-1:0] min_code   = fault2_r[MIN_LSB +: FLD_W];
	wire [FLD_W-1:0] max_code   = fault2_r[MAX_LSB +: FLD_W];
	wire [FLD_W-1:0] retry_code = fault2_r[RTRY_LSB +: FLD_W];
	wire             uv_auto    = fault2_r[UV_MODE];
	wire             ov_auto    = fault2_r[OV_MODE];
	wire [VM_W-1:0]  min_lim    = MIN_TAB[min_code];
	wire [VM_W-1:0]  max_lim    = MAX_TAB[max_code];
	wire [4:0]       retry_max  = RETRY_TAB[retry_code];
	wire             unlimited  = (retry_code == 3'h0);

	// Limit comparison; code 0 disables each side
	wire uv_now = (min_code != 3'h0) && (vm_level < min_lim);
	wire ov_now = (max_code != 3'h0) && (vm_level > max_lim);
	wire in_bounds = !uv_now && !ov_now;
	wire any_fault = uv_fault_r || ov_fault_r;
	// Auto-clear only when every active fault is in auto mode
	wire auto_ok = (!uv_fault_r || uv_auto) && (!ov_fault_r || ov_auto);
	wire exhausted = !unlimited && (tries_r >= retry_max);
	wire wait_done = (wait_cnt_r == 24'h0);
	wire enter_lock = (st_r == F_WAIT) && wait_done && in_bounds && exhausted;
	wire retry_ok   = (st_r == F_WAIT) && wait_done && in_bounds && !exhausted;

	// Fault state sequencing
	always_comb
	begin
		st_nxt = st_r;
		unique case (st_r)
			F_OK:
				// A clear taken during a violation leaves the latch set
				if (uv_now || ov_now || any_fault)
					st_nxt = F_FAULT;
			F_FAULT:
				if (wr_clear)
					st_nxt = F_OK;
				else if (auto_ok)
					st_nxt = F_WAIT;
			F_WAIT:
				if (wr_clear)
					st_nxt = F_OK;
				else if (!auto_ok)
					st_nxt = F_FAULT;
				else if (enter_lock)
					st_nxt = F_LOCKED;
				else if (retry_ok)
					st_nxt = F_OK;
			F_LOCKED:
				if (wr_clear)
					st_nxt = F_OK;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			st_r <= F_OK;
		else
			st_r <= st_nxt;
	end

	// Individual fault latches
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			uv_fault_r <= 1'b0;
			ov_fault_r <= 1'b0;
		end
		else
		begin
			uv_fault_r <= uv_now || (uv_fault_r && !(st_nxt == F_OK));
			ov_fault_r <= ov_now || (ov_fault_r && !(st_nxt == F_OK));
		end
	end

	// Retry spacing and attempt counter
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			wait_cnt_r <= 24'h0;
		else if (st_r != F_WAIT)
			wait_cnt_r <= 24'(RETRY_CYCLES - 1);
		else if (!wait_done)
			wait_cnt_r <= wait_cnt_r - 24'h1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn || wr_clear)
			tries_r <= 5'h0;
		else if (retry_ok && !tries_r[4] || retry_ok && tries_r != 5'h1f)
			tries_r <= tries_r + 5'h1;
	end

	// Configuration and interrupt registers
	assign fault2_nxt = wr_fault2 ? wdata : fault2_r;
	wire [NUM_EVT-1:0] evt;
	assign evt[ST_UV]    = uv_now && !uv_fault_r;
	assign evt[ST_OV]    = ov_now && !ov_fault_r;
	assign evt[ST_RLOCK] = enter_lock;
	wire [NUM_EVT-1:0] istat_clr = wr_istat ? wdata[NUM_EVT-1:0] : '0;

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			fault2_r <= RST_FAULT2;
			istat_r  <= '0;
			imask_r  <= '0;
		end
		else
		begin
			fault2_r <= fault2_nxt;
			istat_r  <= (istat_r & ~istat_clr) | evt;
			if (wr_imask)
				imask_r <= wdata[NUM_EVT-1:0];
		end
	end

	// Read path: local words registered here, bank words inside cfg_regs
	wire [DATA_W-1:0] status_word = {28'h0, st_r == F_LOCKED, ov_fault_r, uv_fault_r,
		drive_en};
	wire [DATA_W-1:0] local_rd =
		hit(addr, IDX_FAULT2)   ? fault2_r :
		hit(addr, IDX_STATUS)   ? status_word :
		hit(addr, IDX_IRQ_STAT) ? {29'h0, istat_r} :
		hit(addr, IDX_IRQ_MASK) ? {29'h0, imask_r} :
		32'h0;

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			rdata_loc_r <= '0;
			rd_bank_r   <= 1'b0;
		end
		else
		begin
			rdata_loc_r <= rd ? local_rd : 32'h0;
			rd_bank_r   <= rd && any_bank;
		end
	end

	assign rdata     = rd_bank_r ? bank_rdata : rdata_loc_r;
	assign drive_en  = (st_r == F_OK) && !any_fault;
	assign fault_out = any_fault;
	assign irq       = |(istat_r & imask_r);
endmodule

// File: shared/supply_fault_pkg.sv
// Constants for the supply-voltage fault block
// Functional notes
// - A 3-bit minimum-supply field disables the floor at code 0 and selects 4.5 to 12.5 V at 1-7.
// - The undervoltage recovery bit latches the fault at 0 and self-clears in bounds at 1.
// - A 3-bit maximum-supply field disables the ceiling at code 0 and selects 20 to 35 V at 1-7.
// - The overvoltage recovery bit latches the fault at 0 and self-clears in bounds at 1.
// - A 3-bit retry field means unlimited at 0 and 2,3,5,7,10,15,20 attempts at 1-7.
// - Six 32-bit configuration registers sit at even offsets 0xa4 to 0xae.
// - An auto-clearing fault retried beyond the limit stops retrying and stays latched.
package supply_fault_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int VM_W   = 12;
	// Register offsets are word indices on the register port
	localparam logic [ADDR_W-1:0] IDX_PIN_CFG  = 8'ha4;
	localparam logic [ADDR_W-1:0] IDX_DEV_CFG1 = 8'ha6;
	localparam logic [ADDR_W-1:0] IDX_DEV_CFG2 = 8'ha8;
	localparam logic [ADDR_W-1:0] IDX_PERI_CFG = 8'haa;
	localparam logic [ADDR_W-1:0] IDX_GD_CFG1  = 8'hac;
	localparam logic [ADDR_W-1:0] IDX_GD_CFG2  = 8'hae;
	localparam logic [ADDR_W-1:0] IDX_FAULT2   = 8'h92;
	localparam logic [ADDR_W-1:0] IDX_STATUS   = 8'h94;
	localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 8'h96;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 8'h98;
	localparam logic [ADDR_W-1:0] IDX_CLEAR    = 8'h9a;
	localparam int NUM_HW_CFG = 6;
	localparam logic [ADDR_W-1:0] HW_CFG_BASE = 8'ha4;
	localparam logic [ADDR_W-1:0] HW_CFG_STEP = 8'h02;
	// Reset values
	localparam logic [DATA_W-1:0] RST_PIN_CFG  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_DEV_CFG1 = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_DEV_CFG2 = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RST_PERI_CFG = 32'h4000_0000;
	localparam logic [DATA_W-1:0] RST_GD_CFG1  = 32'h1022_8100;
	localparam logic [DATA_W-1:0] RST_GD_CFG2  = 32'h0120_0000;
	localparam logic [DATA_W-1:0] RST_FAULT2   = 32'h0000_0000;
	// Fault configuration field positions
	localparam int MIN_LSB  = 8;
	localparam int UV_MODE  = 7;
	localparam int MAX_LSB  = 4;
	localparam int OV_MODE  = 3;
	localparam int RTRY_LSB = 0;
	localparam int FLD_W    = 3;
	// Interrupt bit positions (the status word holds uv, ov and lock at bits 1 to 3)
	localparam int ST_UV    = 0;
	localparam int ST_OV    = 1;
	localparam int ST_RLOCK = 2;
	localparam int NUM_EVT  = 3;
	// Clear-register bit that releases latched faults
	localparam int CLR_BIT  = 0;
	// Supply in units of 0.1 V (steps match the table)
	localparam logic [VM_W-1:0] MIN_TAB [8] = '{12'h000, 12'h02d, 12'h032, 12'h037,
		12'h03c, 12'h04b, 12'h064, 12'h07d};
	localparam logic [VM_W-1:0] MAX_TAB [8] = '{12'h000, 12'h0c8, 12'h0e1, 12'h0fa,
		12'h113, 12'h12c, 12'h145, 12'h15e};
	localparam logic [4:0] RETRY_TAB [8] = '{5'h00, 5'h02, 5'h03, 5'h05,
		5'h07, 5'h0a, 5'h0f, 5'h14};
	// Retry spacing
	localparam int RETRY_US = 1000;
	localparam int CLK_MHZ  = 40;
	localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
	typedef enum logic [1:0] {F_OK, F_FAULT, F_WAIT, F_LOCKED} fault_state_type;
endpackage

// File: hdl/cfg_regs.sv
// Bank of six hardware configuration words, registered read port
`timescale 1ns/1ps
module cfg_regs #(
	parameter int N = supply_fault_pkg::NUM_HW_CFG
) (
	input  wire logic                                 sys_clk, // System clock
	input  wire logic                                 rstn,    // Sync reset, low
	input  wire logic [N-1:0]                         wr_sel,  // One-hot write select
	input  wire logic [supply_fault_pkg::DATA_W-1:0]  wdata,   // Write data
	input  wire logic [$clog2(N)-1:0]                 rd_idx,  // Read index
	output logic      [supply_fault_pkg::DATA_W-1:0]  rdata    // Registered read word
);
	import supply_fault_pkg::*;
	localparam logic [DATA_W-1:0] RST_TAB [NUM_HW_CFG] = '{RST_PIN_CFG, RST_DEV_CFG1,
		RST_DEV_CFG2, RST_PERI_CFG, RST_GD_CFG1, RST_GD_CFG2};
	logic [DATA_W-1:0] mem_r [N];
	initial
	begin
		if (N != NUM_HW_CFG)
			$error("cfg_regs: bank size must match the register map");
	end
	for (genvar i = 0; i < N; i++)
	begin : g_word
		always_ff @(posedge sys_clk)
		begin
			if (!rstn)
				mem_r[i] <= RST_TAB[i];
			else if (wr_sel[i])
				mem_r[i] <= wdata;
		end
	end
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			rdata <= '0;
		else
			rdata <= mem_r[rd_idx];
	end
endmodule

// File: bench/supply_fault_props.sv
// Port checker for the supply fault block
`timescale 1ns/1ps
module supply_fault_props (
	input wire logic        sys_clk,   // Clock
	input wire logic        rstn,      // Reset, low
	input wire logic [7:0]  addr,      // Index
	input wire logic [31:0] wdata,     // Write data
	input wire logic        wr,        // Write
	input wire logic        rd,        // Read
	input wire logic [31:0] rdata,     // Read data
	input wire logic [11:0] vm_level,  // Supply
	input wire logic        drive_en,  // Drive on
	input wire logic        fault_out  // Fault
);
	import supply_fault_pkg::*;
	logic [10:0] cfg_r;
	wire low_v = cfg_r[10:8] != 3'h0 && vm_level < MIN_TAB[cfg_r[10:8]];
	wire high_v = cfg_r[6:4] != 3'h0 && vm_level > MAX_TAB[cfg_r[6:4]];
	wire clr_wr = wr && addr == 8'h9a && wdata[0];
	wire auto_on = cfg_r[7] && cfg_r[3] && cfg_r[2:0] == 3'h0;
	wire mapped = addr inside {8'h92, 8'h94, 8'h96, 8'h98, 8'h9a,
		8'ha4, 8'ha6, 8'ha8, 8'haa, 8'hac, 8'hae};
	// Shadow of the limits, so no internal probes are needed
	always_ff @(posedge sys_clk)
		if (!rstn)
			cfg_r <= 11'h0;
		else if (wr && addr == 8'h92)
			cfg_r <= wdata[10:0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence calm_s;
		(!low_v && !high_v && !wr) [*8];
	endsequence
	sequence status_rd_s;
		rd && addr == 8'h94;
	endsequence
	uv_floor_a: assert property (low_v |-> ##[1:2] fault_out)
		else $error("undervoltage not flagged");
	ov_ceiling_a: assert property (high_v |-> ##[1:2] fault_out)
		else $error("overvoltage not flagged");
	latch_hold_a: assert property (fault_out && !cfg_r[7] && !cfg_r[3] && !clr_wr |=> fault_out)
		else $error("latched fault dropped");
	auto_clear_a: assert property (fault_out && auto_on ##1 calm_s |-> ##[0:4] !fault_out)
		else $error("auto fault not cleared");
	cfg_read_a: assert property (rd && addr == 8'h92 |=> rdata[10:0] == $past(cfg_r))
		else $error("fault config read wrong");
	unmapped_read_a: assert property (rd && !mapped |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	drive_block_a: assert property (fault_out |-> !drive_en)
		else $error("drive on during fault");
	lock_fault_a: assert property (status_rd_s ##1 rdata[3] |-> fault_out)
		else $error("locked without fault");
	status_drive_a: assert property (status_rd_s |=> rdata[0] == $past(drive_en))
		else $error("status drive bit wrong");
endmodule

bind supply_fault supply_fault_props props_i (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .vm_level(vm_level),
	.drive_en(drive_en), .fault_out(fault_out));

// File: bench/supply_fault_tb_top.sv
// Self-checking bench for the supply fault block
`timescale 1ns/1ps
module supply_fault_tb_top;
	import supply_fault_pkg::*;
	logic        sys_clk, rstn, wr, rd, drive_en, fault_out, irq;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, got;
	logic [11:0] vm_level;
	int          miscompares, check_count;
	logic [31:0] rst_tab [6] = '{RST_PIN_CFG, RST_DEV_CFG1, RST_DEV_CFG2, RST_PERI_CFG,
		RST_GD_CFG1, RST_GD_CFG2};
	// Short retry wait keeps the retry scenarios brief
	supply_fault #(.RETRY_CYCLES(4)) dut (.sys_clk(sys_clk), .rstn(rstn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .vm_level(vm_level),
		.drive_en(drive_en), .fault_out(fault_out), .irq(irq));
	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic setv(input logic [11:0] v);
		@(posedge sys_clk);
		vm_level <= v;
	endtask
	task automatic results;
		$display("Checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		#200us;
		miscompares++;
		results();
	end
	initial
	begin
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		vm_level = 12'h0f0;
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		rreg(8'h92);
		chk("cfg reset", 32'h0, got);
		for (int i = 0; i < 6; i++)
		begin
			rreg(8'ha4 + 8'(2 * i));
			chk("bank reset", rst_tab[i], got);
			wreg(8'ha4 + 8'(2 * i), 32'h5a00_0000 + 32'(i));
			rreg(8'ha4 + 8'(2 * i));
			chk("bank data", 32'h5a00_0000 + 32'(i), got);
		end
		// Reserved offsets are only ever read by the host
		rreg(8'ha5);
		chk("unmapped", 32'h0, got);
		for (int m = 0; m < 2; m++)
			for (int c = 1; c < 8; c++)
			begin
				setv(m ? MAX_TAB[c] : MIN_TAB[c]);
				wreg(8'h92, m ? 32'(c) << 4 : 32'(c) << 8);
				wreg(8'h9a, 32'h1);
				cyc(3);
				chk("at limit", 32'h0, fault_out);
				setv(m ? MAX_TAB[c] + 12'h1 : MIN_TAB[c] - 12'h1);
				cyc(3);
				chk("past limit", 32'h1, fault_out);
				chk("drive", 32'h0, drive_en);
				setv(m ? 12'h064 : 12'h0f0);
				cyc(12);
				rreg(8'h94);
				chk("latched", m ? 32'h4 : 32'h2, 32'(got[3:0]));
				wreg(8'h9a, 32'h1);
				cyc(3);
				chk("released", 32'h0, fault_out);
			end
		wreg(8'h92, 32'h0);
		setv(12'h000);
		cyc(3);
		chk("no floor", 32'h0, fault_out);
		setv(12'hfff);
		cyc(3);
		chk("no ceiling", 32'h0, fault_out);
		wreg(8'h96, 32'h7);
		for (int m = 0; m < 2; m++)
		begin
			wreg(8'h98, m ? 32'h2 : 32'h1);
			wreg(8'h92, m ? 32'h98 : 32'h788);
			setv(m ? 12'h0c9 : 12'h064);
			cyc(3);
			chk("irq set", 32'h1, irq);
			setv(m ? 12'h064 : 12'h0f0);
			cyc(16);
			chk("auto clear", 32'h0, fault_out);
			chk("irq sticky", 32'h1, irq);
			wreg(8'h96, 32'h3);
			cyc(2);
			chk("irq clear", 32'h0, irq);
		end
		wreg(8'h98, 32'h0);
		setv(12'h0c9);
		cyc(3);
		chk("masked", 32'h0, irq);
		rreg(8'h96);
		chk("event bit", 32'h2, 32'(got[2:0]));
		setv(12'h064);
		for (int c = 1; c < 3; c++)
		begin
			setv(12'h0f0);
			wreg(8'h92, 32'h788 | 32'(c));
			wreg(8'h9a, 32'h1);
			for (int n = 0; n <= int'(RETRY_TAB[c]); n++)
			begin
				setv(12'h064);
				cyc(3);
				setv(12'h0f0);
				cyc(16);
				chk("retry", n == int'(RETRY_TAB[c]) ? 32'h1 : 32'h0, fault_out);
			end
			rreg(8'h94);
			chk("lock bit", 32'h1, 32'(got[3]));
		end
		results();
	end
endmodule
